// ==== eep_pkg.sv ====
/*
  Shared constants and types of the serial word-memory command block:
  command encoding, word and address widths, write timing and state codes.
  Assumes a single 40 MHz system clock drives all logic that uses it.
*/
package eep_pkg;
	// system clock rate in Hz
	localparam int EEP_SYS_CLK_HZ = 40_000_000;
	// word and address widths; command unit is start + 2 opcode bits + address
	localparam int EEP_DATA_W = 16;
	localparam int EEP_ADDR_W = 5;
	localparam int EEP_OP_W = 2;
	// opcode field values
	localparam logic [1:0] EEP_OP_EXT = 2'h0;
	localparam logic [1:0] EEP_OP_PROG = 2'h1;
	localparam logic [1:0] EEP_OP_READ = 2'h2;
	// extended commands, selected by the two top address bits under EEP_OP_EXT
	localparam logic [1:0] EEP_EXT_BLOCK = 2'h0;
	localparam logic [1:0] EEP_EXT_FILL = 2'h1;
	localparam logic [1:0] EEP_EXT_ERASE = 2'h2;
	localparam logic [1:0] EEP_EXT_ALLOW = 2'h3;
	// write latch state after reset: writes blocked
	localparam logic EEP_WRITE_ALLOW_RST = 1'b0;
	// write_duration: typical figure used for the busy time, and the ceiling
	localparam int EEP_WRITE_DURATION_US = 4000;
	localparam int EEP_WRITE_DURATION_MAX_US = 10000;
	localparam int EEP_WRITE_CYCLES = EEP_WRITE_DURATION_US * (EEP_SYS_CLK_HZ / 1_000_000);
	localparam int EEP_WRITE_MAX_CYCLES =
		EEP_WRITE_DURATION_MAX_US * (EEP_SYS_CLK_HZ / 1_000_000);

	typedef enum logic [2:0] {
		EEP_ST_IDLE,
		EEP_ST_CMD,
		EEP_ST_READ,
		EEP_ST_DATA,
		EEP_ST_HOLD,
		EEP_ST_BUSY
	} eep_state_t;

	typedef enum logic [1:0] {
		EEP_WR_PROG,
		EEP_WR_FILL,
		EEP_WR_ERASE
	} eep_wr_t;
endpackage

// ==== eep_sync_if.sv ====
/*
  Carrier for the synchronised pin levels and serial clock edge pulses.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface eep_sync_if;
	logic cs;
	logic din;
	logic prot;
	logic sclk_rise;
	logic sclk_fall;
	modport src (output cs, output din, output prot, output sclk_rise, output sclk_fall);
	modport dst (input cs, input din, input prot, input sclk_rise, input sclk_fall);
endinterface
`default_nettype wire

// ==== eep_sync.sv ====
/*
  Two-stage synchronisers for the four host pins and edge detection of the
  serial clock. Assumes pins are asynchronous to sys_clk and the serial clock
  is far slower than sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module eep_sync (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cs_pin,
	input wire logic sclk_pin,
	input wire logic din_pin,
	input wire logic prot_pin,
	eep_sync_if.src sy
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic sclk_d;
	} eep_sync_t;

	eep_sync_t r;
	eep_sync_t next_r;

	// first stage is read only by the second; edge detect looks at stage two
	always_comb begin
		next_r = r;
		next_r.s1 = {prot_pin, din_pin, sclk_pin, cs_pin};
		next_r.s2 = r.s1;
		next_r.sclk_d = r.s2[1];
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// din and cs share the same latency as the edge pulses, so they line up
	assign sy.cs = r.s2[0];
	assign sy.din = r.s2[2];
	assign sy.prot = r.s2[3];
	assign sy.sclk_rise = r.s2[1] & ~r.sclk_d;
	assign sy.sclk_fall = ~r.s2[1] & r.sclk_d;
endmodule
`default_nettype wire

// ==== eep_core.sv ====
/*
  Command interface of a serial word memory: start detection, command and
  data shifting, sequential read, single-word and whole-array writes, write
  latch, busy/ready polling on data-out and lower-bank protection.
  Assumes host pins arrive asynchronously and a tri-state buffer outside
  combines data_out with data_out_oe_n.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - with select high, first clock edge sampling data-in high is the start
// - start, opcode, address, data arrive in order, sampled on rising edges
// - select low means standby; clock and data-in are ignored
// - start bit, opcode and address form one eight-bit command unit
// - read shifts the addressed word out, msb first, on falling edges
// - continued clocking streams the following words without a new command
// - read address wraps from the top word back to zero
// - writes start when select falls after enough clocks
// - an internal write finishes within the maximum write duration
// - select high while writing shows low busy, then high ready
// - all serial activity is ignored during an internal write
// - a start bit during ready display releases data-out
// - program writes one word; only the final sixteen data bits count
// - fill writes one word everywhere; last sixteen bits are used
// - erase sets every bit to one and needs no data
// - allow enables writes; block makes write commands rejected
// - writes are blocked after reset
// - protect low keeps the lower half of the array unwritten
// - a protected write still keeps the device busy the full time
module eep_core
	import eep_pkg::*;
#(
	parameter int ADDR_W = EEP_ADDR_W,
	parameter int DATA_W = EEP_DATA_W,
	parameter int WRITE_CYCLES = EEP_WRITE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic chip_select,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic protect_in,
	output logic data_out,
	output logic data_out_oe_n
);
	localparam int CMD_W = EEP_OP_W + ADDR_W;
	localparam int WORDS = 1 << ADDR_W;
	localparam int CW = $clog2(DATA_W + 1);
	localparam int BW = $clog2(WRITE_CYCLES + 1);
	localparam logic [CW-1:0] CMD_LAST = CW'(CMD_W - 1);
	localparam logic [CW-1:0] BIT_LAST = CW'(DATA_W - 1);
	localparam logic [CW-1:0] DATA_FULL = CW'(DATA_W);
	localparam logic [BW-1:0] BUSY_LAST = BW'(WRITE_CYCLES - 1);
	localparam logic [BW-1:0] BUSY_WORDS = BW'(WORDS);

	typedef struct packed {
		eep_state_t st;
		eep_wr_t op;
		logic [CW-1:0] cnt;
		logic [CMD_W-1:0] cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] shreg;
		logic [DATA_W-1:0] wdata;
		logic [BW-1:0] busy_cnt;
		logic allow;
		logic prot;
		logic ready;
		logic dout;
		logic dout_oe_n;
	} eep_regs_t;

	eep_regs_t r;
	eep_regs_t next_r;
	eep_sync_if sy ();
	logic [DATA_W-1:0] mem [WORDS];
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic [CMD_W-1:0] full_cmd;
	logic [ADDR_W-1:0] addr_inc;

	eep_sync u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.cs_pin(chip_select),
		.sclk_pin(serial_clock_in),
		.din_pin(serial_data_in),
		.prot_pin(protect_in),
		.sy(sy)
	);

	// command word including the bit sampled on this edge
	assign full_cmd = {r.cmd[CMD_W-2:0], sy.din};
	assign addr_inc = ADDR_W'(r.addr + 1'b1);

	// next-state logic of the whole command engine
	always_comb begin
		next_r = r;
		mem_we = 1'b0;
		mem_waddr = r.addr;
		mem_wdata = r.wdata;
		unique case (r.st)
			EEP_ST_IDLE: begin
				// ready stays on data-out only while select is high
				if (!sy.cs) begin
					next_r.dout_oe_n = 1'b1;
				end else if (r.ready) begin
					next_r.dout = 1'b1;
					next_r.dout_oe_n = 1'b0;
				end
				if (sy.cs && sy.sclk_rise && sy.din) begin
					next_r.st = EEP_ST_CMD;
					next_r.cnt = '0;
					next_r.ready = 1'b0;
					next_r.dout_oe_n = 1'b1;
				end
			end
			EEP_ST_CMD: begin
				if (!sy.cs) begin
					next_r.st = EEP_ST_IDLE;
				end else if (sy.sclk_rise) begin
					next_r.cmd = full_cmd;
					next_r.cnt = CW'(r.cnt + 1'b1);
					if (r.cnt == CMD_LAST) begin
						next_r.addr = full_cmd[ADDR_W-1:0];
						next_r.cnt = '0;
						unique case (full_cmd[CMD_W-1 -: EEP_OP_W])
							EEP_OP_READ: begin
								next_r.st = EEP_ST_READ;
								next_r.shreg = mem[full_cmd[ADDR_W-1:0]];
							end
							EEP_OP_PROG: begin
								next_r.st = EEP_ST_DATA;
								next_r.op = EEP_WR_PROG;
							end
							EEP_OP_EXT: begin
								unique case (full_cmd[ADDR_W-1 -: 2])
									EEP_EXT_ALLOW: begin
										next_r.allow = 1'b1;
										next_r.st = EEP_ST_HOLD;
									end
									EEP_EXT_BLOCK: begin
										next_r.allow = 1'b0;
										next_r.st = EEP_ST_HOLD;
									end
									EEP_EXT_FILL: begin
										next_r.st = EEP_ST_DATA;
										next_r.op = EEP_WR_FILL;
									end
									EEP_EXT_ERASE: begin
										// no data phase: the clock count is already met
										next_r.st = EEP_ST_DATA;
										next_r.op = EEP_WR_ERASE;
										next_r.cnt = DATA_FULL;
									end
								endcase
							end
							default: begin
								// unused opcode: sit out the rest of the frame
								next_r.st = EEP_ST_HOLD;
							end
						endcase
					end
				end
			end
			EEP_ST_READ: begin
				if (!sy.cs) begin
					next_r.st = EEP_ST_IDLE;
					next_r.dout_oe_n = 1'b1;
				end else if (sy.sclk_fall) begin
					next_r.dout = r.shreg[DATA_W-1];
					next_r.dout_oe_n = 1'b0;
					if (r.cnt == BIT_LAST) begin
						// word done: fetch the next one, address wraps naturally
						next_r.cnt = '0;
						next_r.addr = addr_inc;
						next_r.shreg = mem[addr_inc];
					end else begin
						next_r.cnt = CW'(r.cnt + 1'b1);
						next_r.shreg = {r.shreg[DATA_W-2:0], 1'b0};
					end
				end
			end
			EEP_ST_DATA: begin
				if (!sy.cs) begin
					// a short or unallowed write is dropped without going busy
					if (r.cnt == DATA_FULL && r.allow) begin
						next_r.st = EEP_ST_BUSY;
						next_r.busy_cnt = '0;
						next_r.prot = sy.prot;
					end else begin
						next_r.st = EEP_ST_IDLE;
					end
				end else if (sy.sclk_rise) begin
					// extra bits push older ones out, keeping the last word
					next_r.wdata = {r.wdata[DATA_W-2:0], sy.din};
					if (r.cnt != DATA_FULL) begin
						next_r.cnt = CW'(r.cnt + 1'b1);
					end
				end
			end
			EEP_ST_HOLD: begin
				if (!sy.cs) begin
					next_r.st = EEP_ST_IDLE;
				end
			end
			EEP_ST_BUSY: begin
				// pins ignored except select, which only gates the busy display
				next_r.dout = 1'b0;
				next_r.dout_oe_n = ~sy.cs;
				if (r.op == EEP_WR_PROG) begin
					mem_we = (r.busy_cnt == '0) && (r.prot || r.addr[ADDR_W-1]);
				end else begin
					// whole-array writes walk one word per cycle early in the busy time
					mem_waddr = r.busy_cnt[ADDR_W-1:0];
					mem_wdata = (r.op == EEP_WR_ERASE) ? '1 : r.wdata;
					mem_we = (r.busy_cnt < BUSY_WORDS) && (r.prot || mem_waddr[ADDR_W-1]);
				end
				// busy time runs in full even when protection blocked the write
				if (r.busy_cnt == BUSY_LAST) begin
					next_r.st = EEP_ST_IDLE;
					next_r.ready = 1'b1;
				end else begin
					next_r.busy_cnt = BW'(r.busy_cnt + 1'b1);
				end
			end
		endcase
	end

	// state register; write latch comes up blocked
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.st <= EEP_ST_IDLE;
			r.op <= EEP_WR_PROG;
			r.allow <= EEP_WRITE_ALLOW_RST;
			r.dout_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// array has no reset: contents are nonvolatile in intent
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	assign data_out = r.dout;
	assign data_out_oe_n = r.dout_oe_n;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_last_addr_bit;
		r.st == EEP_ST_CMD && sy.cs && sy.sclk_rise && r.cnt == CMD_LAST;
	endsequence

	sequence s_read_cmd;
		s_last_addr_bit ##0 full_cmd[CMD_W-1 -: EEP_OP_W] == EEP_OP_READ;
	endsequence

	sequence s_write_close;
		r.st == EEP_ST_DATA && !sy.cs && r.cnt == DATA_FULL;
	endsequence

	start_ignore_a: assert property (
		r.st == EEP_ST_IDLE && sy.sclk_rise && !sy.din |=> r.st == EEP_ST_IDLE)
		else $error("clock with data-in low left idle");
	standby_drop_a: assert property (
		r.st inside {EEP_ST_CMD, EEP_ST_READ, EEP_ST_HOLD} && !sy.cs
		|=> r.st == EEP_ST_IDLE && $stable(r.allow))
		else $error("select low did not return to standby");
	read_load_a: assert property (
		s_read_cmd |=> r.st == EEP_ST_READ && r.cnt == '0 && r.shreg == mem[r.addr])
		else $error("read did not load the addressed word");
	read_wrap_a: assert property (
		r.st == EEP_ST_READ && sy.cs && sy.sclk_fall && r.cnt == BIT_LAST
		|=> r.addr == ADDR_W'($past(r.addr) + 1'b1) && r.cnt == '0)
		else $error("read address did not advance or wrap");
	busy_start_a: assert property (
		s_write_close ##0 r.allow |=> r.st == EEP_ST_BUSY && r.busy_cnt == '0)
		else $error("write did not start at select fall");
	write_reject_a: assert property (
		r.st == EEP_ST_DATA && !sy.cs && !r.allow |=> r.st == EEP_ST_IDLE [*2])
		else $error("blocked write was not rejected");
	busy_bound_a: assert property (
		// widen before comparing: the ceiling does not fit a short simulation counter
		32'(r.busy_cnt) < EEP_WRITE_MAX_CYCLES
		&& (r.st != EEP_ST_BUSY || r.busy_cnt <= BUSY_LAST))
		else $error("internal write overran its duration");
	busy_hold_a: assert property (
		r.st == EEP_ST_BUSY && r.busy_cnt != BUSY_LAST |=> r.st == EEP_ST_BUSY && !r.ready)
		else $error("busy state left early");
	poll_busy_a: assert property (
		r.st == EEP_ST_BUSY && sy.cs |=> !data_out && !data_out_oe_n)
		else $error("busy not shown low on data-out");
	poll_ready_a: assert property (
		r.st == EEP_ST_IDLE && r.ready && sy.cs && !sy.sclk_rise |-> ##[1:2] data_out && !data_out_oe_n)
		else $error("ready not shown high on data-out");
	start_release_a: assert property (
		r.st == EEP_ST_IDLE && r.ready && sy.cs && sy.sclk_rise && sy.din
		|=> data_out_oe_n && !r.ready)
		else $error("start bit did not release data-out");
	bank_guard_a: assert property (
		mem_we && !r.prot |-> mem_waddr[ADDR_W-1])
		else $error("write reached protected lower bank");
endmodule
`default_nettype wire

// ==== eep_host.sv ====
/*
  Host serial port model that drives select, clock and data-in pins.
  Assumes sys_clk at 40 MHz, so one serial clock of 200 ns is 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module eep_host (
	input wire logic sys_clk,
	input wire logic dout,
	output logic cs,
	output logic sclk,
	output logic din,
	output logic prot
);
	// pins idle low; the clock stands still outside frames; protect low as if pulled down
	task automatic rest;
		cs <= 1'b0;
		sclk <= 1'b0;
		din <= 1'b0;
		prot <= 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// select change, then a full deselect interval before anything else
	task automatic sel(input logic s);
		cs <= s;
		din <= 1'b0;
		tick(8);
	endtask
	// protect only moves between commands, never inside one
	task automatic setp(input logic p);
		prot <= p;
		tick(2);
	endtask
	// data set in the low phase, taken by the device at the rise
	task automatic bit1(input logic b);
		din <= b;
		tick(4);
		sclk <= 1'b1;
		tick(4);
		sclk <= 1'b0;
	endtask
	task automatic send(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) bit1(v[i]);
	endtask
	// sample halfway through the high phase, well after the falling edge launched the bit
	task automatic rd(output logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			din <= 1'b0;
			tick(4);
			sclk <= 1'b1;
			tick(2);
			#1 w[i] = dout;
			tick(2);
			sclk <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ==== test_eep_core.sv ====
/*
  Self-checking bench of the command block: writes, protection, latch and reads.
  Assumes eep_host drives the pins; busy time shortened through WRITE_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none
module test_eep_core import eep_pkg::*;;
	localparam int WC = 400;
	logic sys_clk;
	logic rst;
	logic cs, sclk, din, prot, data_out, data_out_oe_n;
	wire dout;
	int fails = 0;
	int total_checks = 0;
	int seed = 32'he343daa7;
	logic [15:0] eq[$];
	logic [15:0] sq[$];
	string nq[$];
	always #12.5 sys_clk = ~sys_clk;
	// released line floats, so a stale level can never pass as a match
	assign dout = data_out_oe_n ? 1'bz : data_out;
	eep_host u_eep_host (.sys_clk(sys_clk), .dout(dout), .cs(cs), .sclk(sclk), .din(din),
		.prot(prot));
	eep_core #(.WRITE_CYCLES(WC)) u_eep_core (.sys_clk(sys_clk), .rst(rst), .chip_select(cs),
		.serial_clock_in(sclk), .serial_data_in(din), .protect_in(prot),
		.data_out(data_out), .data_out_oe_n(data_out_oe_n));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic note(input string n, input logic [15:0] e, input logic [15:0] s);
		nq.push_back(n);
		eq.push_back(e);
		sq.push_back(s);
	endtask
	// monitor takes the oldest expectation whenever a result lands
	initial forever begin
		wait (sq.size() > 0);
		chk(nq.pop_front(), sq.pop_front(), eq.pop_front());
	end
	task automatic end_of_test;
		wait (sq.size() == 0);
		#1 $display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a clock with data low first, then start; idle says whether status is free
	task automatic cmd(input logic [7:0] c, input logic [31:0] d, input int n, input bit idle);
		u_eep_host.sel(1'b1);
		u_eep_host.bit1(1'b0);
		u_eep_host.bit1(1'b1);
		u_eep_host.tick(2);
		#1 note("oe_n at start", {15'h0, idle}, {15'h0, data_out_oe_n});
		u_eep_host.send({25'h0, c[6:0]}, 7);
		u_eep_host.send(d, n);
	endtask
	task automatic wr(input logic [7:0] c, input logic [31:0] d, input int n, input bit idle);
		cmd(c, d, n, idle);
		u_eep_host.sel(1'b0);
	endtask
	// poll status: low while busy, high once done, within the busy time
	task automatic poll(input int lo);
		int k;
		u_eep_host.sel(1'b1);
		#1 note("busy", 16'h0000, {15'h0, dout});
		k = 0;
		while (dout !== 1'b1 && k < 4 * WC) begin
			@(posedge sys_clk);
			#1 k++;
		end
		note("ready", 16'h0001, {15'h0, dout});
		note("write time", 16'h0001, {15'h0, k > lo && k <= WC});
		u_eep_host.sel(1'b0);
	endtask
	task automatic idle_chk;
		u_eep_host.sel(1'b1);
		#1 note("oe_n idle", 16'h0001, {15'h0, data_out_oe_n});
		u_eep_host.sel(1'b0);
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e[4], input int n);
		logic [15:0] w;
		cmd({1'b1, EEP_OP_READ, a}, 32'h0, 0, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_eep_host.rd(w);
			note("word", e[i], w);
		end
		u_eep_host.sel(1'b0);
	endtask
	initial begin
		logic [15:0] v1, v2, v31, vf;
		sys_clk = 1'b0;
		rst = 1'b1;
		u_eep_host.rest();
		v1 = 16'($random(seed));
		v2 = 16'($random(seed));
		v31 = 16'($random(seed));
		vf = 16'($random(seed));
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		// erase before any allow must be dropped
		wr({1'b1, EEP_OP_EXT, EEP_EXT_ERASE, 3'h0}, 32'h0, 0, 1'b1);
		idle_chk();
		wr({1'b1, EEP_OP_EXT, EEP_EXT_ALLOW, 3'h0}, 32'h0, 0, 1'b1);
		// protect lifted so the erase reaches both halves, later reads rely on it
		u_eep_host.setp(1'b1);
		wr({1'b1, EEP_OP_EXT, EEP_EXT_ERASE, 3'h2}, 32'h0, 0, 1'b1);
		wr({1'b1, EEP_OP_PROG, 5'h14}, {16'h0, v1}, 16, 1'b0);
		poll(0);
		$display("test erase done");
		u_eep_host.setp(1'b0);
		wr({1'b1, EEP_OP_PROG, 5'h01}, {16'h0, v1}, 16, 1'b1);
		poll(WC - 24);
		u_eep_host.setp(1'b1);
		wr({1'b1, EEP_OP_PROG, 5'h02}, {12'h0, 4'hA, v2}, 20, 1'b1);
		poll(WC - 24);
		wr({1'b1, EEP_OP_PROG, 5'h1F}, {16'h0, v31}, 16, 1'b1);
		poll(WC - 24);
		$display("test program done");
		rd(5'h1F, '{v31, 16'hFFFF, 16'hFFFF, v2}, 4);
		rd(5'h14, '{16'hFFFF, 16'h0, 16'h0, 16'h0}, 1);
		$display("test read done");
		wr({1'b1, EEP_OP_EXT, EEP_EXT_BLOCK, 3'h0}, 32'h0, 0, 1'b1);
		wr({1'b1, EEP_OP_PROG, 5'h05}, {16'h0, v1}, 16, 1'b1);
		idle_chk();
		rd(5'h05, '{16'hFFFF, 16'h0, 16'h0, 16'h0}, 1);
		$display("test latch done");
		wr({1'b1, EEP_OP_EXT, EEP_EXT_ALLOW, 3'h0}, 32'h0, 0, 1'b1);
		u_eep_host.setp(1'b0);
		wr({1'b1, EEP_OP_EXT, EEP_EXT_FILL, 3'h5}, {12'h0, 4'h5, vf}, 20, 1'b1);
		poll(WC - 24);
		rd(5'h0F, '{16'hFFFF, vf, 16'h0, 16'h0}, 2);
		$display("test fill done");
		end_of_test();
	end
	// watchdog: the whole sequence needs well under 30000 cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		fails++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule
`default_nettype wire
